// file: tbrg_pkg.sv
/*
 * Shared constants of the timer baud rate generator: count limits, reset values,
 * timebase division and the serial port modes that accept the generated ticks.
 * Assumes the user includes nothing else; every use is written tbrg_pkg::name.
 */
package tbrg_pkg;

    // ********************************************************************
    // Counter geometry and reset values
    // ********************************************************************
    localparam int          COUNT_WIDTH      = 16;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [15:0] COUNT_MAX        = 16'hffff;
    localparam logic [15:0] COUNT_WRAP       = 16'h0000;
    localparam logic [15:0] COUNT_ONE        = 16'h0001;

    // ********************************************************************
    // Timebase and serial port modes
    // ********************************************************************
    localparam int          INTERNAL_DIVIDE  = 2;
    localparam int          SERIAL_OVERSAMPLE = 16;
    localparam logic [1:0]  SERIAL_MODE_ONE  = 2'h1;
    localparam logic [1:0]  SERIAL_MODE_THREE = 2'h3;
    localparam logic        FLAG_RESET       = 1'h0;

endpackage : tbrg_pkg

// file: tbrg_edge_sync.sv
/*
 * Two-stage synchroniser with a falling-edge detector for one slow pin.
 * Assumes the pin is treated as synchronous but may still change near the clock
 * edge, so it is resampled before any edge is looked for.
 */
`timescale 1ns/100ps

module tbrg_edge_sync
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      fall_pulse
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // synchronise before detection
    // The first stage feeds only the second; the edge is seen between stages two and three.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= 1'h1;
            sync_reg <= 1'h1;
            last_reg <= 1'h1;
        end
        else
        begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign fall_pulse = last_reg & ~sync_reg;

endmodule : tbrg_edge_sync

// file: tbrg_top.sv
/*
 * Sixteen-bit up-counter with auto-reload, used as the baud clock source of the
 * serial port, plus its external count and trigger inputs and its two flags.
 * Assumes the serial port divides each shift tick by sixteen and that control
 * inputs are static or synchronous to clk_sys.
 */
// Overview of operation
// - Shift ticks reach the serial port only while it runs in mode one or mode three.
// - Each overflow in baud mode loads the reload value high and low bytes into the counter.
// - In baud mode an overflow leaves the overflow flag untouched and raises no interrupt.
// - Each overflow in baud mode becomes one shift tick on each selected direction while the port runs in mode one or three.
// - Receive and transmit ticks are enabled by their own separate select inputs.
// - Either clock select being set places the timer in baud mode for that direction.
// - With either clock select set the counter auto-reloads whatever the capture select says.
// - With the internal timebase the counter advances once every two system clocks.
// - Internal baud rate is system clock over 32 times (65536 minus reload).
// - With counter mode selected the counter steps on external pin edges, rate pin over 16 times the span.
// - With trigger enable set a falling trigger edge sets the trigger flag and may interrupt, even in baud mode.
`timescale 1ns/100ps

module tbrg_top
#(
    parameter int COUNT_W = tbrg_pkg::COUNT_WIDTH
)
(
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    input  wire logic               timer_run,
    input  wire logic               receive_clock_select,
    input  wire logic               transmit_clock_select,
    input  wire logic               capture_or_reload_select,
    input  wire logic               counter_mode_select,
    input  wire logic               external_trigger_enable,
    input  wire logic               interrupt_enable,
    input  wire logic [1:0]         serial_mode,
    input  wire logic [COUNT_W/2-1:0] reload_value_high,
    input  wire logic [COUNT_W/2-1:0] reload_value_low,
    input  wire logic               overflow_flag_clear,
    input  wire logic               trigger_flag_clear,
    input  wire logic               external_count_pin,
    input  wire logic               external_trigger_pin,
    output logic [COUNT_W-1:0]      count_value,
    output logic                    counter_overflow_flag,
    output logic                    external_trigger_flag,
    output logic                    timer_interrupt,
    output logic                    rx_shift_tick,
    output logic                    tx_shift_tick,
    output logic                    baud_mode_active
);

    // ********************************************************************
    // Elaboration checks
    // ********************************************************************
    // The reload value is split into two equal bytes, so the width must be even.
    if ((COUNT_W % 2) != 0 || COUNT_W < 4 || COUNT_W > tbrg_pkg::COUNT_WIDTH)
    begin : g_bad_width
        $error("tbrg_top: COUNT_W must be even and between 4 and 16");
    end

    // ********************************************************************
    // Declarations
    // ********************************************************************
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic               div_reg;
    logic               ovf_flag_reg;
    logic               trig_flag_reg;
    logic               irq_reg;
    logic               rx_tick_reg;
    logic               tx_tick_reg;
    logic               ext_count_fall;
    logic               ext_trig_fall;
    logic               baud_mode;
    logic               reload_mode;
    logic               serial_ok;
    logic               int_tick;
    logic               tb_tick;
    logic               ovf_evt;
    logic               at_max;
    logic [COUNT_W-1:0] reload_word;

    // ********************************************************************
    // Pin synchronisers
    // ********************************************************************
    tbrg_edge_sync u_count_sync
    (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .pin_in     (external_count_pin),
        .fall_pulse (ext_count_fall)
    );

    tbrg_edge_sync u_trig_sync
    (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .pin_in     (external_trigger_pin),
        .fall_pulse (ext_trig_fall)
    );

    // ********************************************************************
    // Mode decode and timebase
    // ********************************************************************
    // either select enters baud mode
    assign baud_mode   = receive_clock_select | transmit_clock_select;
    assign reload_mode = baud_mode | ~capture_or_reload_select;
    assign serial_ok   = (serial_mode == tbrg_pkg::SERIAL_MODE_ONE) |
                         (serial_mode == tbrg_pkg::SERIAL_MODE_THREE);
    assign reload_word = {reload_value_high, reload_value_low};
    assign int_tick    = timer_run & div_reg;
    assign tb_tick     = counter_mode_select ? (timer_run & ext_count_fall) : int_tick;
    assign at_max      = (count_reg == tbrg_pkg::COUNT_MAX[COUNT_W-1:0]);
    assign ovf_evt     = tb_tick & at_max;

    // span of 65536 minus reload sets the rate
    // increment, reload in the overflow cycle
    // Loading on the same edge as the wrap keeps the period exactly 65536 minus reload ticks.
    assign count_next  = !tb_tick ? count_reg :
                         !at_max  ? count_reg + tbrg_pkg::COUNT_ONE[COUNT_W-1:0] :
                         reload_mode ? reload_word : tbrg_pkg::COUNT_WRAP[COUNT_W-1:0];

    // The divider phase restarts whenever the timer stops, so the first step takes two clocks.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            div_reg <= 1'h0;
        else
            div_reg <= timer_run & ~div_reg;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            count_reg <= tbrg_pkg::COUNT_RESET[COUNT_W-1:0];
        else
            count_reg <= count_next;
    end

    // ********************************************************************
    // Flags and interrupt
    // ********************************************************************
    // overflow flag only outside baud mode
    // trigger flag in every mode
    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ovf_flag_reg  <= tbrg_pkg::FLAG_RESET;
            trig_flag_reg <= tbrg_pkg::FLAG_RESET;
        end
        else
        begin
            ovf_flag_reg  <= (ovf_evt & ~baud_mode) | (ovf_flag_reg & ~overflow_flag_clear);
            trig_flag_reg <= (ext_trig_fall & external_trigger_enable) |
                             (trig_flag_reg & ~trigger_flag_clear);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_reg <= 1'h0;
        else
            irq_reg <= interrupt_enable & (ovf_flag_reg | trig_flag_reg);
    end

    // ********************************************************************
    // Shift ticks toward the serial port
    // ********************************************************************
    // one tick per overflow
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_tick_reg <= 1'h0;
            tx_tick_reg <= 1'h0;
        end
        else
        begin
            rx_tick_reg <= ovf_evt & receive_clock_select & serial_ok;
            tx_tick_reg <= ovf_evt & transmit_clock_select & serial_ok;
        end
    end

    assign count_value           = count_reg;
    assign counter_overflow_flag = ovf_flag_reg;
    assign external_trigger_flag = trig_flag_reg;
    assign timer_interrupt       = irq_reg;
    assign rx_shift_tick         = rx_tick_reg;
    assign tx_shift_tick         = tx_tick_reg;
    assign baud_mode_active      = baud_mode;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_baud_ovf;
        ovf_evt && baud_mode;
    endsequence

    sequence s_int_step;
        timer_run && !counter_mode_select && !div_reg;
    endsequence

    chk_reload_on_ovf: assert property (ovf_evt && reload_mode |=> count_reg == $past(reload_word))
        else $error("counter did not take the reload value after overflow");

    chk_flag_quiet_baud: assert property (s_baud_ovf ##0 !ovf_flag_reg |=> !ovf_flag_reg)
        else $error("overflow flag set in baud mode");

    chk_rx_tick_cause: assert property (rx_tick_reg |-> $past(ovf_evt && receive_clock_select && serial_ok))
        else $error("receive tick without overflow");

    chk_tx_tick_route: assert property (s_baud_ovf ##0 transmit_clock_select && serial_ok |=> tx_tick_reg)
        else $error("transmit tick missing after overflow");

    chk_serial_mode_gate: assert property (!serial_ok |=> !rx_tick_reg && !tx_tick_reg)
        else $error("tick delivered in a fixed-rate serial mode");

    // capture select ignored in baud mode
    chk_capture_ignored: assert property (s_baud_ovf ##0 capture_or_reload_select
                                          |=> count_reg == $past(reload_word))
        else $error("baud mode did not auto-reload");

    // internal counter steps every second clock
    // A reload of the all-ones value leaves the count unchanged, so an overflow step is excused.
    chk_half_rate_step: assert property (s_int_step ##1 (timer_run && !counter_mode_select) ##1 timer_run
                                         |-> $past(count_reg) == $past(count_reg, 2)
                                         && (count_reg != $past(count_reg) || $past(at_max)))
        else $error("internal timebase not divided by two");

    chk_trigger_sets: assert property (ext_trig_fall && external_trigger_enable |=> trig_flag_reg [*1])
        else $error("trigger edge did not set the trigger flag");

    chk_edge_once: assert property (counter_mode_select && !ext_count_fall |=> count_reg == $past(count_reg))
        else $error("external edge seen twice");

    chk_step_by_one: assert property (tb_tick && !at_max |=> count_reg == $past(count_reg) + 1'b1)
        else $error("counter did not step by one");

endmodule : tbrg_top

// file: tbrg_serial_model.sv
/*
 * Behavioural model of the serial port shift logic fed by the timer ticks.
 * Assumes one-cycle tick pulses on clk_sys; sixteen ticks form one bit time.
 */
`timescale 1ns/100ps

module tbrg_serial_model
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        rx_shift_tick,
    input  wire logic        tx_shift_tick,
    output logic [15:0]      rx_tick_count,
    output logic [15:0]      tx_tick_count,
    output logic [11:0]      tx_bit_count
);
    // ********************************************************************
    // Tick counting
    // ********************************************************************
    // Every tick is counted, so a stray or doubled tick shows in the totals.
    // one tick each
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_tick_count <= 16'h0000;
            tx_tick_count <= 16'h0000;
        end
        else
        begin
            rx_tick_count <= rx_tick_count + {15'h0000, rx_shift_tick};
            tx_tick_count <= tx_tick_count + {15'h0000, tx_shift_tick};
        end
    end

    // The port oversamples, so one bit time is sixteen ticks.
    // divide by sixteen
    assign tx_bit_count = tx_tick_count[15:4];

endmodule : tbrg_serial_model

// file: tb_top.sv
/*
 * Self-checking bench of the baud rate generator with an 8-bit counter.
 * Assumes the serial port model stands on the tick outputs.
 */
`timescale 1ns/100ps

module tb_top;
    localparam int W = 8;
    localparam int SPAN = 1 << W;
    typedef struct { logic rx; logic tx; logic [W-1:0] cnt; int gap; } tbrg_exp_t;
    logic clk_sys = 1'b0, rst_n = 1'b0, timer_run = 1'b0, rxs = 1'b0, txs = 1'b0;
    logic cap_sel = 1'b0, ext_sel = 1'b0, trig_en = 1'b0, irq_en = 1'b0;
    logic ovf_clr = 1'b0, trig_clr = 1'b0, cnt_pin = 1'b1, trig_pin = 1'b1;
    logic [1:0] serial_mode = 2'h0;
    logic [W/2-1:0] rl_hi = 4'h0, rl_lo = 4'h0;
    logic [W-1:0] count_value;
    logic ovf_flag, trig_flag, timer_interrupt, rx_tick, tx_tick, baud_on;
    logic [15:0] rx_cnt, tx_cnt;
    int fail_count = 0, n_checks = 0, cyc = 0, last = 0;
    tbrg_exp_t exp_q[$];

    tbrg_top #(.COUNT_W(W)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .timer_run(timer_run),
        .receive_clock_select(rxs), .transmit_clock_select(txs), .capture_or_reload_select(cap_sel),
        .counter_mode_select(ext_sel), .external_trigger_enable(trig_en), .interrupt_enable(irq_en),
        .serial_mode(serial_mode), .reload_value_high(rl_hi), .reload_value_low(rl_lo),
        .overflow_flag_clear(ovf_clr), .trigger_flag_clear(trig_clr), .external_count_pin(cnt_pin),
        .external_trigger_pin(trig_pin), .count_value(count_value), .counter_overflow_flag(ovf_flag),
        .external_trigger_flag(trig_flag), .timer_interrupt(timer_interrupt), .rx_shift_tick(rx_tick),
        .tx_shift_tick(tx_tick), .baud_mode_active(baud_on));
    tbrg_serial_model i_port (.clk_sys(clk_sys), .rst_n(rst_n), .rx_shift_tick(rx_tick),
        .tx_shift_tick(tx_tick), .rx_tick_count(rx_cnt), .tx_tick_count(tx_cnt), .tx_bit_count());

    // ********************************************************************
    // Clock, external timebase and shared tasks
    // ********************************************************************
    // The external pin runs with a period of eight clocks, slow enough for the synchroniser.
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    always @(posedge clk_sys) #1 cnt_pin = (cyc % 8) < 4;

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : check

    task automatic do_reset();
        rst_n = 1'b0;
        timer_run = 1'b0;
        step(2);
        rst_n = 1'b1;
        step(1);
        check("count_reset", 0, count_value);
    endtask : do_reset

    // ********************************************************************
    // Scenarios
    // ********************************************************************
    // Baud mode run: reload value, capture select and trigger enable are random.
    task automatic run_baud(input logic [1:0] mode, input logic rx, input logic tx, input logic ext);
        logic [W-1:0] r;
        int g;
        int lim;
        logic tick_mode;
        r = W'($urandom_range(SPAN - 1, ext ? SPAN - 48 : SPAN / 2));
        g = (SPAN - r) * (ext ? 8 : 2);
        do_reset();
        serial_mode = mode;
        rxs = rx;
        txs = tx;
        ext_sel = ext;
        cap_sel = 1'($urandom_range(1, 0));
        trig_en = 1'($urandom_range(1, 0));
        irq_en = 1'b1;
        {rl_hi, rl_lo} = r;
        tick_mode = mode[0] && (rx || tx);
        if (tick_mode)
            for (int i = 0; i < 3; i++) exp_q.push_back('{rx, tx, r, (i == 0) ? 0 : g});
        timer_run = 1'b1;
        step(20);
        trig_pin = 1'b0;
        step(6);
        check("trig_flag", trig_en, trig_flag);
        check("trig_irq", trig_en, timer_interrupt);
        trig_clr = 1'b1;
        step(1);
        trig_clr = 1'b0;
        step(4);
        check("trig_once", 0, trig_flag);
        trig_pin = 1'b1;
        // Stop the timer once the third tick is taken, so a fourth overflow never lands as a stray.
        lim = SPAN * (ext ? 8 : 2) + 3 * g + 40;
        for (int k = 0; k < lim && !(tick_mode && exp_q.size() == 0); k++)
            step(1);
        timer_run = 1'b0;
        step(2);
        check("ticks_left", 0, exp_q.size());
        exp_q.delete();
        check("rx_ticks", (mode[0] && rx) ? 3 : 0, rx_cnt);
        check("tx_ticks", (mode[0] && tx) ? 3 : 0, tx_cnt);
    endtask : run_baud

    // Timer mode with wrap: the overflow flag must set and interrupt.
    task automatic run_timer();
        int k;
        do_reset();
        rxs = 1'b0;
        txs = 1'b0;
        ext_sel = 1'b0;
        cap_sel = 1'b1;
        timer_run = 1'b1;
        k = 0;
        while (ovf_flag !== 1'b1 && k < 2 * SPAN + 20)
        begin
            step(1);
            k++;
        end
        check("ovf_time", 1, k >= 2 * SPAN - 2 && k <= 2 * SPAN + 2);
        check("wrap_count", 0, count_value[W-1:1]);
        check("baud_off", 0, baud_on);
        step(1);
        check("ovf_irq", 1, timer_interrupt);
        ovf_clr = 1'b1;
        step(1);
        ovf_clr = 1'b0;
        step(1);
        check("ovf_clear", 0, ovf_flag);
    endtask : run_timer

    // Tick watcher: every tick takes the oldest expectation off the queue.
    // Sampling on the falling edge sees the registered outputs settled, clear of the launching edge.
    always @(negedge clk_sys)
    begin
        tbrg_exp_t e;
        if (rst_n && (rx_tick || tx_tick))
        begin
            if (exp_q.size() == 0)
                check("stray_tick", 0, 1);
            else
            begin
                e = exp_q.pop_front();
                check("rx_tick", e.rx, rx_tick);
                check("tx_tick", e.tx, tx_tick);
                check("reload", e.cnt, count_value);
                check("no_ovf", 0, ovf_flag);
                check("baud_on", 1, baud_on);
                if (e.gap != 0)
                    check("tick_gap", e.gap, cyc - last);
            end
            last = cyc;
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // Main sequence.
    initial
    begin
        void'($urandom(68));
        step(6);
        rst_n = 1'b1;
        for (int m = 0; m < 4; m++) run_baud(2'(m), 1'b1, 1'b1, 1'b0);
        run_baud(2'h1, 1'b1, 1'b0, 1'b0);
        run_baud(2'h3, 1'b0, 1'b1, 1'b0);
        run_baud(2'h1, 1'b1, 1'b1, 1'b1);
        run_timer();
        final_report();
    end

    // Watchdog for a hung run.
    initial
    begin
        #200000;
        fail_count++;
        final_report();
    end

endmodule : tb_top
